/* ppc_edge_det.sv */
// Edge detector for the host control lines
`timescale 1ns/10ps
module ppc_edge_det
    import ppc_pkg::*;
#(
    parameter int W = HOST_W
) (
    // Clock and reset
    input logic clk,
    input logic rst_b,
    // Lines and edges
    input logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] prev;
        logic armed;
    } ppc_edge_s;

    ppc_edge_s st;
    ppc_edge_s next_st;

    always_comb begin
        next_st.prev = level;
        next_st.armed = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Nothing fires before the first sample after reset
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign rise[i] = st.armed & level[i] & ~st.prev[i];
        assign fall[i] = st.armed & ~level[i] & st.prev[i];
    end
endmodule : ppc_edge_det

/* ppc_host_model.sv */
// Host computer model on the cable side of the pin control block
`timescale 1ns/10ps
module ppc_host_model
    import ppc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Levels the host is told to put on its lines
    input wire logic [DLINE_W-1:0] data_cmd,
    input wire logic [HOST_W-1:0] host_cmd,
    // Status drive from the block
    input wire logic [STATUS_W-1:0] stat_line_out,
    input wire logic [STATUS_W-1:0] stat_line_oe,
    // Cable levels seen by the block
    output logic [DLINE_W-1:0] data_line_in,
    output logic [HOST_W-1:0] host_line_in,
    output logic [STATUS_W-1:0] stat_line_in
);
    logic [STATUS_W-1:0] last_drv;

    // Host lines move just after an edge, like a real cable sampled late
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_line_in <= 8'h00;
            host_line_in <= 4'h1;
            // Lines never driven since reset settle low
            last_drv <= 5'h1F;
        end else begin
            data_line_in <= data_cmd;
            host_line_in <= host_cmd;
            for (int i = 0; i < STATUS_W; i++) begin
                if (stat_line_oe[i]) begin
                    last_drv[i] <= stat_line_out[i];
                end
            end
        end
    end

    // released line floats
    // No pull-up on the cable, so a released line shows the opposite level
    always_comb begin
        for (int i = 0; i < STATUS_W; i++) begin
            stat_line_in[i] = stat_line_oe[i] ? stat_line_out[i]
                : ~last_drv[i];
        end
    end
endmodule : ppc_host_model

/* ppc_irq_ctrl.sv */
// Sticky interrupt flags with read clear, write-one clear and enable
`timescale 1ns/10ps
module ppc_irq_ctrl
    import ppc_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic rst_b,
    // Events and control
    input logic [IRQ_W-1:0] set_evt,
    input logic [IRQ_W-1:0] enable,
    input logic rd_clr,
    input logic [IRQ_W-1:0] wr_clr,
    // Flags and request
    output logic [IRQ_W-1:0] status,
    output logic irq
);
    typedef struct packed {
        logic [IRQ_W-1:0] status;
        logic irq;
    } ppc_irq_s;

    ppc_irq_s st;
    ppc_irq_s next_st;
    logic [IRQ_W-1:0] clr;
    logic [IRQ_W-1:0] set;

    always_comb begin
        clr = rd_clr ? IRQ_IMPL : wr_clr;
        // Flags only latch while their enable is set
        set = set_evt & enable & IRQ_IMPL;
        // A set in the clearing cycle survives
        next_st.status = (st.status & ~clr) | set;
        next_st.irq = |(next_st.status & enable);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign status = st.status;
    assign irq = st.irq;
endmodule : ppc_irq_ctrl

/* ppc_pkg.sv */
// Package: register map, field layout and decoding of the pin control block
package ppc_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int BYTE_W = 8;

    // Byte addresses of the registers
    localparam logic [ADDR_W-1:0] ADDR_DATA = 32'h9040_0100;
    localparam logic [ADDR_W-1:0] ADDR_HOST = 32'h9040_0104;
    localparam logic [ADDR_W-1:0] ADDR_DRIVE = 32'h9040_0108;
    localparam logic [ADDR_W-1:0] ADDR_READBACK = 32'h9040_010C;
    localparam logic [ADDR_W-1:0] ADDR_PORT_EN = 32'h9040_0114;
    localparam logic [ADDR_W-1:0] ADDR_SETUP_B = 32'h9040_0118;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 32'h9040_011C;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 32'h9040_0120;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 32'h9040_012C;

    // Line widths and field positions
    localparam int DLINE_W = 8;
    localparam int HOST_W = 4;
    localparam int HOST_STROBE = 0;
    localparam int HOST_SELECTIN = 1;
    localparam int STATUS_LSB = 3;
    localparam int STATUS_W = 5;
    localparam int PORT_EN_BIT = 0;
    localparam int SETUP_BIT = 0;
    localparam int IRQ_W = 6;
    localparam int IRQ_XFER = 0;
    localparam int IRQ_NEG = 1;
    localparam int IRQ_CHAN = 4;
    localparam int IRQ_PSEL = 5;
    localparam logic [IRQ_W-1:0] IRQ_IMPL = 6'h33;
    localparam int MODE_W = 7;
    localparam int MODE_NEG = 2;
    localparam int MODE_XFER = 4;
    localparam int MODE_SPP = 5;
    localparam int MODE_ECP = 6;
    localparam logic [MODE_W-1:0] MODE_MASK = 7'h74;

    // Reset values
    localparam logic [STATUS_W-1:0] DRIVE_RST = 5'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;
    localparam logic [MODE_W-1:0] MODE_RST = 7'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        REG_NONE, REG_DATA, REG_HOST, REG_DRIVE, REG_READBACK,
        REG_PORT_EN, REG_SETUP_B, REG_IRQ_EN, REG_MODE, REG_IRQ_STAT
    } ppc_reg_e;

    function automatic ppc_reg_e ppc_decode(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_DATA: ppc_decode = REG_DATA;
            ADDR_HOST: ppc_decode = REG_HOST;
            ADDR_DRIVE: ppc_decode = REG_DRIVE;
            ADDR_READBACK: ppc_decode = REG_READBACK;
            ADDR_PORT_EN: ppc_decode = REG_PORT_EN;
            ADDR_SETUP_B: ppc_decode = REG_SETUP_B;
            ADDR_IRQ_EN: ppc_decode = REG_IRQ_EN;
            ADDR_MODE: ppc_decode = REG_MODE;
            ADDR_IRQ_STAT: ppc_decode = REG_IRQ_STAT;
            default: ppc_decode = REG_NONE;
        endcase
    endfunction : ppc_decode
endpackage : ppc_pkg

/* ppc_top.sv */
// Top: AXI4-Lite registers, status line drive and port events
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
// Function
// - Data register returns live data lines
// - Host register returns live control lines
// - Drive register holds five status bits
// - Software drives lines only with modes off
// - Readback register returns actual status lines
// - Port enable low forces outputs high impedance
// - Enable bit five gates pin select
// - Enable bit four gates channel address
// - Selectin rise raises negotiation start outside ECP mode
// - Strobe fall raises transfer start outside ECP mode
// - Status read clears all flags except one set in the same cycle
// - Both auto enables give hardware control
module ppc_top
    import ppc_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic rst_b,
    // AXI4-Lite write channels
    input logic [ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [DATA_W-1:0] s_axi_wdata,
    input logic [STRB_W-1:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // AXI4-Lite read channels
    input logic [ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // Port lines from the cable
    input logic [DLINE_W-1:0] data_line_in,
    input logic [HOST_W-1:0] host_line_in,
    input logic [STATUS_W-1:0] stat_line_in,
    // Status lines to the cable
    output logic [STATUS_W-1:0] stat_line_out,
    output logic [STATUS_W-1:0] stat_line_oe,
    // Protocol engines
    input logic [STATUS_W-1:0] eng_stat_in,
    input logic chan_addr_evt,
    input logic pin_select_evt,
    output logic hw_auto_ctrl,
    // Interrupt
    output logic irq
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [DATA_W-1:0] rdata;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [BYTE_W-1:0] wdata;
        logic wstrb0;
        logic [STATUS_W-1:0] drive;
        logic port_en;
        logic setup_b;
        logic [IRQ_W-1:0] irq_en;
        logic [MODE_W-1:0] mode;
        logic [STATUS_W-1:0] readback;
        logic [STATUS_W-1:0] line_out;
        logic [STATUS_W-1:0] line_oe;
        logic hw_auto;
    } ppc_top_s;

    ppc_top_s st;
    ppc_top_s next_st;
    logic [HOST_W-1:0] host_rise;
    logic [HOST_W-1:0] host_fall;
    logic [IRQ_W-1:0] evt;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] wr_clr;
    logic rd_clr;
    logic sw_owns;
    logic compat;
    logic ar_hs;
    logic do_write;
    ppc_reg_e rd_sel;
    ppc_reg_e wr_sel;

    ppc_edge_det #(
        .W(HOST_W)
    ) u_edge (
        .clk(clk),
        .rst_b(rst_b),
        .level(host_line_in),
        .rise(host_rise),
        .fall(host_fall)
    );

    ppc_irq_ctrl u_irq (
        .clk(clk),
        .rst_b(rst_b),
        .set_evt(evt),
        .enable(st.irq_en),
        .rd_clr(rd_clr),
        .wr_clr(wr_clr),
        .status(irq_status),
        .irq(irq)
    );

    always_comb begin
        rd_sel = ppc_decode(s_axi_araddr);
        wr_sel = ppc_decode(st.awaddr);
        ar_hs = s_axi_arvalid & st.arready;
        do_write = st.aw_got & st.w_got;
        // Line ownership goes to software only with every mode off
        sw_owns = (st.mode & MODE_MASK) == MODE_RST;
        compat = ~st.mode[MODE_ECP];
        evt = IRQ_RST;
        evt[IRQ_XFER] = compat & host_fall[HOST_STROBE];
        evt[IRQ_NEG] = compat & host_rise[HOST_SELECTIN];
        evt[IRQ_CHAN] = chan_addr_evt;
        evt[IRQ_PSEL] = pin_select_evt;
        rd_clr = ar_hs & (rd_sel == REG_IRQ_STAT);
        wr_clr = IRQ_RST;
        if (do_write && st.wstrb0 && wr_sel == REG_IRQ_STAT) begin
            wr_clr = st.wdata[IRQ_W-1:0];
        end

        next_st = st;
        // Write channels, taken in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata[BYTE_W-1:0];
            next_st.wstrb0 = s_axi_wstrb[0];
        end
        if (do_write) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            if (wr_sel == REG_NONE) begin
                next_st.bresp = RESP_SLVERR;
            end
            // Every field lives in byte lane 0
            if (st.wstrb0) begin
                case (wr_sel)
                    REG_DRIVE: begin
                        next_st.drive = st.wdata[STATUS_LSB +: STATUS_W];
                    end
                    REG_PORT_EN: begin
                        next_st.port_en = st.wdata[PORT_EN_BIT];
                    end
                    REG_SETUP_B: begin
                        next_st.setup_b = st.wdata[SETUP_BIT];
                    end
                    REG_IRQ_EN: begin
                        next_st.irq_en = st.wdata[IRQ_W-1:0] & IRQ_IMPL;
                    end
                    REG_MODE: begin
                        next_st.mode = st.wdata[MODE_W-1:0] & MODE_MASK;
                    end
                    default: begin
                        next_st.mode = st.mode;
                    end
                endcase
            end
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        next_st.awready = ~next_st.aw_got & ~next_st.bvalid;
        next_st.wready = ~next_st.w_got & ~next_st.bvalid;

        // Read channel: data captured at the address handshake
        if (ar_hs) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            case (rd_sel)
                REG_DATA: next_st.rdata = DATA_W'(data_line_in);
                REG_HOST: next_st.rdata = DATA_W'(host_line_in);
                REG_DRIVE: next_st.rdata = DATA_W'(st.drive) << STATUS_LSB;
                REG_READBACK: begin
                    next_st.rdata = DATA_W'(st.readback) << STATUS_LSB;
                end
                REG_PORT_EN: next_st.rdata = DATA_W'(st.port_en);
                REG_SETUP_B: next_st.rdata = DATA_W'(st.setup_b);
                REG_IRQ_EN: next_st.rdata = DATA_W'(st.irq_en);
                REG_MODE: next_st.rdata = DATA_W'(st.mode);
                REG_IRQ_STAT: next_st.rdata = DATA_W'(irq_status);
                default: begin
                    next_st.rdata = '0;
                    next_st.rresp = RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        next_st.arready = ~next_st.rvalid;

        next_st.readback = stat_line_in;
        next_st.line_out = sw_owns ? st.drive : eng_stat_in;
        next_st.line_oe = {STATUS_W{st.port_en}};
        next_st.hw_auto = st.mode[MODE_XFER] & st.mode[MODE_NEG];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    assign stat_line_out = st.line_out;
    assign stat_line_oe = st.line_oe;
    assign hw_auto_ctrl = st.hw_auto;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_DATA_LIVE: assert property (
        ar_hs && rd_sel == REG_DATA
        |=> s_axi_rdata == DATA_W'($past(data_line_in)) && s_axi_rvalid)
        else $error("Data read does not match lines");
    AST_HOST_LIVE: assert property (
        ar_hs && rd_sel == REG_HOST
        |=> s_axi_rdata == DATA_W'($past(host_line_in)))
        else $error("Host read does not match lines");
    AST_DRIVE_OUT: assert property (
        sw_owns && st.port_en |=> stat_line_out == $past(st.drive)
        && stat_line_oe != '0)
        else $error("Drive bits not on lines");
    AST_ENGINE_OWN: assert property (
        !sw_owns |=> stat_line_out == $past(eng_stat_in))
        else $error("Engine lines not passed out");
    AST_READBACK: assert property (
        ##1 ar_hs && rd_sel == REG_READBACK
        |=> s_axi_rdata[STATUS_LSB +: STATUS_W] == $past(stat_line_in, 2))
        else $error("Readback differs from lines");
    AST_HIZ: assert property (
        !st.port_en |=> stat_line_oe == '0)
        else $error("Outputs driven while disabled");
    AST_PSEL_GATE: assert property (
        pin_select_evt && !st.irq_en[IRQ_PSEL] && !rd_clr
        && !wr_clr[IRQ_PSEL] |=> irq_status[IRQ_PSEL]
        == $past(irq_status[IRQ_PSEL]))
        else $error("Pin select flag set while disabled");
    AST_CHAN_SET: assert property (
        chan_addr_evt && st.irq_en[IRQ_CHAN] |=> irq_status[IRQ_CHAN])
        else $error("Channel address flag not set");
    AST_NEG_START: assert property (
        compat && host_rise[HOST_SELECTIN] && st.irq_en[IRQ_NEG]
        |=> irq_status[IRQ_NEG] && irq)
        else $error("Negotiation start not raised");
    AST_XFER_START: assert property (
        compat && host_fall[HOST_STROBE] && st.irq_en[IRQ_XFER]
        |=> irq_status[IRQ_XFER])
        else $error("Transfer start not raised");
    AST_RD_CLEAR: assert property (
        rd_clr && (evt & st.irq_en) == IRQ_RST |=> irq_status == IRQ_RST)
        else $error("Status read did not clear");
    AST_AUTO: assert property (
        hw_auto_ctrl |-> $past(st.mode[MODE_XFER] && st.mode[MODE_NEG]))
        else $error("Hardware control without both enables");
    AST_IRQ_OUT: assert property (
        irq == |(irq_status & $past(st.irq_en)))
        else $error("Interrupt output wrong");

    COV_WRITE: cover property (do_write && wr_sel == REG_DRIVE);
    COV_XFER_IRQ: cover property (evt[IRQ_XFER] && st.irq_en[IRQ_XFER]
        ##[1:8] rd_clr);
    COV_SET_CLR: cover property (rd_clr && (evt & st.irq_en) != IRQ_RST);
    COV_UNMAPPED: cover property (ar_hs && rd_sel == REG_NONE);
endmodule : ppc_top

/* testbench.sv */
// Self-checking bench for the pin control block over AXI4-Lite
`timescale 1ns/10ps
module testbench;
    import ppc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, hw_auto_ctrl, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [7:0] data_cmd = 8'h00, data_line_in;
    logic [3:0] host_cmd = 4'h1, host_line_in;
    logic [4:0] stat_line_in, stat_line_out, stat_line_oe;
    logic [4:0] eng_stat_in = 5'h15;
    logic chan_addr_evt = 0, pin_select_evt = 0;
    int miscompares = 0, total_checks = 0;
    logic [31:0] evt_bit [4] = '{32'h01, 32'h02, 32'h10, 32'h20};

    ppc_top ppc_top_inst (.clk(clk), .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .data_line_in(data_line_in),
        .host_line_in(host_line_in), .stat_line_in(stat_line_in),
        .stat_line_out(stat_line_out), .stat_line_oe(stat_line_oe),
        .eng_stat_in(eng_stat_in), .chan_addr_evt(chan_addr_evt),
        .pin_select_evt(pin_select_evt), .hw_auto_ctrl(hw_auto_ctrl),
        .irq(irq));

    ppc_host_model ppc_host_model_inst (.clk(clk), .rst_b(rst_b),
        .data_cmd(data_cmd), .host_cmd(host_cmd),
        .stat_line_out(stat_line_out), .stat_line_oe(stat_line_oe),
        .data_line_in(data_line_in), .host_line_in(host_line_in),
        .stat_line_in(stat_line_in));

    always #5 clk = ~clk;

    task final_report;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk

    // Address and data offered together, each dropped once taken
    task axi_wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (n >= 100) begin
            miscompares++;
            final_report();
        end
    endtask : axi_wr

    task axi_rd(input logic [31:0] a);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        if (n >= 100) begin
            miscompares++;
            final_report();
        end
    endtask : axi_rd

    task rd_chk(input logic [31:0] a, input logic [31:0] exp);
        axi_rd(a);
        chk(rd, exp);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
    endtask : rd_chk

    // Raise one port event: strobe fall, selectin rise, channel, pin select
    task fire(input int k);
        @(posedge clk);
        case (k)
            0: host_cmd[0] <= 1'b0;
            1: host_cmd[1] <= 1'b1;
            2: chan_addr_evt <= 1'b1;
            default: pin_select_evt <= 1'b1;
        endcase
        @(posedge clk);
        chan_addr_evt <= 1'b0;
        pin_select_evt <= 1'b0;
        repeat (3) @(posedge clk);
        host_cmd <= 4'h1;
        repeat (4) @(posedge clk);
    endtask : fire

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        chk({27'h0, stat_line_oe}, 32'h0);
        rd_chk(ADDR_DRIVE, 32'h0);
        rd_chk(ADDR_READBACK, 32'h0);
        rd_chk(ADDR_PORT_EN, 32'h0);
        rd_chk(ADDR_IRQ_EN, 32'h0);
        data_cmd <= 8'hA5;
        host_cmd <= 4'hB;
        rd_chk(ADDR_DATA, 32'hA5);
        rd_chk(ADDR_HOST, 32'hB);
        axi_wr(ADDR_DATA, 32'h5A);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        axi_wr(ADDR_HOST, 32'h4);
        rd_chk(ADDR_DATA, 32'hA5);
        rd_chk(ADDR_HOST, 32'hB);
        host_cmd <= 4'h1;
        axi_rd(32'h9040_0110);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        chk(rd, 32'h0);
        axi_wr(32'h9040_0110, 32'h1);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_wr(ADDR_SETUP_B, 32'h1);
        rd_chk(ADDR_SETUP_B, 32'h1);
        axi_wr(ADDR_DRIVE, 32'hFF);
        rd_chk(ADDR_DRIVE, 32'hF8);
        axi_wr(ADDR_PORT_EN, 32'h1);
        repeat (3) @(posedge clk);
        chk({27'h0, stat_line_oe}, 32'h1F);
        chk({27'h0, stat_line_out}, 32'h1F);
        rd_chk(ADDR_READBACK, 32'hF8);
        axi_wr(ADDR_DRIVE, 32'h50);
        repeat (3) @(posedge clk);
        chk({27'h0, stat_line_out}, 32'h0A);
        rd_chk(ADDR_READBACK, 32'h50);
        axi_wr(ADDR_MODE, 32'h14);
        repeat (3) @(posedge clk);
        chk({31'h0, hw_auto_ctrl}, 32'h1);
        chk({27'h0, stat_line_out}, 32'h15);
        axi_wr(ADDR_MODE, 32'h10);
        repeat (3) @(posedge clk);
        chk({31'h0, hw_auto_ctrl}, 32'h0);
        axi_wr(ADDR_MODE, 32'h04);
        repeat (3) @(posedge clk);
        chk({31'h0, hw_auto_ctrl}, 32'h0);
        axi_wr(ADDR_MODE, 32'h0);
        repeat (3) @(posedge clk);
        chk({27'h0, stat_line_out}, 32'h0A);
        // Each event enabled alone, then read to clear
        for (int k = 0; k < 4; k++) begin
            axi_wr(ADDR_IRQ_EN, evt_bit[k]);
            fire(k);
            chk({31'h0, irq}, 32'h1);
            rd_chk(ADDR_IRQ_STAT, evt_bit[k]);
            repeat (2) @(posedge clk);
            chk({31'h0, irq}, 32'h0);
            rd_chk(ADDR_IRQ_STAT, 32'h0);
        end
        // Masked events leave no flag
        axi_wr(ADDR_IRQ_EN, 32'h0);
        for (int k = 0; k < 4; k++) fire(k);
        chk({31'h0, irq}, 32'h0);
        rd_chk(ADDR_IRQ_STAT, 32'h0);
        // Write-one clear of a pending flag
        axi_wr(ADDR_IRQ_EN, 32'h33);
        fire(0);
        fire(2);
        axi_wr(ADDR_IRQ_STAT, 32'h01);
        rd_chk(ADDR_IRQ_STAT, 32'h10);
        // Outside compatibility mode the host edges are ignored
        axi_wr(ADDR_MODE, 32'h40);
        fire(0);
        fire(1);
        chk({31'h0, irq}, 32'h0);
        rd_chk(ADDR_IRQ_STAT, 32'h0);
        axi_wr(ADDR_PORT_EN, 32'h0);
        repeat (3) @(posedge clk);
        chk({27'h0, stat_line_oe}, 32'h0);
        final_report();
    end
endmodule : testbench
